// ===== rtl/dtwt_defines.svh
// Offsets, reset values and timing figures of the double tap window timer.
`ifndef DTWT_DEFINES_SVH
`define DTWT_DEFINES_SVH
// Register offsets on the serial register interface.
`define DTWT_OFS_TIME_LIMIT   8'h26
`define DTWT_OFS_LATENCY      8'h27
`define DTWT_OFS_WINDOW       8'h28
// Reset values of the settings.
`define DTWT_RST_SETTING      8'h00
// Longest programmable count.
`define DTWT_MAX_COUNT        8'hFF
// Base tick of the sample engine, 800 Hz, in microseconds and in clock cycles.
`define DTWT_BASE_TICK_US     1250
`define DTWT_CLK_MHZ          125
`define DTWT_BASE_TICK_CYC    (`DTWT_BASE_TICK_US * `DTWT_CLK_MHZ)
// Largest step multiple without hybrid mode, 1280 ms over 1.25 ms.
`define DTWT_MAX_MULT         1024
`endif

// ===== rtl/dtwt_pkg.sv
// Types shared by the double tap window timer.
package dtwt_pkg;
  // Output data rate code, 800 Hz down to 1.56 Hz.
  typedef enum logic [2:0] {
    DTWT_ODR_800  = 3'h0,
    DTWT_ODR_400  = 3'h1,
    DTWT_ODR_200  = 3'h2,
    DTWT_ODR_100  = 3'h3,
    DTWT_ODR_50   = 3'h4,
    DTWT_ODR_12P5 = 3'h5,
    DTWT_ODR_6P25 = 3'h6,
    DTWT_ODR_1P56 = 3'h7
  } dtwt_odr_t;
  // Power mode.
  typedef enum logic [1:0] {
    DTWT_PM_NORMAL = 2'h0,
    DTWT_PM_LOW_POWER_LOW_NOISE_MODE   = 2'h1,
    DTWT_PM_HIRES  = 2'h2,
    DTWT_PM_LOWPWR = 2'h3
  } dtwt_pm_t;
  // Detector phases.
  typedef enum logic [2:0] {
    DTWT_ST_IDLE    = 3'h0,
    DTWT_ST_FIRST   = 3'h1,
    DTWT_ST_LATENCY = 3'h2,
    DTWT_ST_WINDOW  = 3'h3,
    DTWT_ST_SECOND  = 3'h4
  } dtwt_state_t;
endpackage

// ===== rtl/dtwt_tick_if.sv
// Tick strobes passed from the step generator to the detector.
`timescale 1ns/1ps
interface dtwt_tick_if;
  logic lim_tick;  // One step of the time limit counter.
  logic lat_tick;  // One step of the latency counter.
  logic win_tick;  // One step of the window counter.
  modport gen (output lim_tick, output lat_tick, output win_tick);
  modport use_ (input lim_tick, input lat_tick, input win_tick);
endinterface

// ===== rtl/dtwt_step_gen.sv
// Step generator: base tick divider and per-setting step strobes.
`timescale 1ns/1ps
`include "dtwt_defines.svh"
module dtwt_step_gen import dtwt_pkg::*; #(
  parameter int unsigned BASE_CYC = `DTWT_BASE_TICK_CYC
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Rate settings.
  input  wire dtwt_odr_t  odr,
  input  wire dtwt_pm_t   pmode,
  input  wire logic       lowpass_filter_on,
  input  wire logic       hybrid_mode,
  // Step strobes.
  dtwt_tick_if.gen        tk
);
  // All state in one record.
  typedef struct packed {
    logic [23:0] base_cnt;  // Cycles inside one base tick.
    logic [10:0] step_cnt;  // Base ticks since step zero.
  } dtwt_gen_t;
  dtwt_gen_t s_q, s_d;
  logic      base_tick;  // One pulse per 1.25 ms.

  // Step multiple in base ticks for the window and latency tables. The slow
  // rates are not one octave apart, so each rate code first maps to its
  // doubling level below 800 Hz: 12.5 Hz is six octaves down, 1.56 Hz nine.
  function automatic logic [11:0] dtwt_mult(input dtwt_odr_t o, input dtwt_pm_t p,
                                            input logic lpf, input logic hyb);
    logic [11:0] m;
    logic [3:0]  r;
    case (o)
      DTWT_ODR_12P5: begin
        r = 4'h6;
      end
      DTWT_ODR_6P25: begin
        r = 4'h7;
      end
      DTWT_ODR_1P56: begin
        r = 4'h9;
      end
      default: begin
        r = {1'b0, o};
      end
    endcase
    // High resolution stops slowing at 400 Hz, normal mode at 50 Hz.
    if (p == DTWT_PM_HIRES) begin
      r = (r > 4'h1) ? 4'h1 : r;
    end else if (p == DTWT_PM_NORMAL) begin
      r = (r > 4'h4) ? 4'h4 : r;
    end
    if (lpf) begin
      m = 12'h002 << r;
    end else if (p == DTWT_PM_LOWPWR) begin
      m = 12'h001 << r;
    end else begin
      m = (r == 4'h0) ? 12'h001 : (12'h001 << (r - 4'h1));
    end
    // Hybrid mode halves the rate, so every step doubles.
    if (hyb) begin
      m = m << 1;
    end
    return m;
  endfunction

  logic [11:0] win_mult;  // Window and latency step in base ticks, up to 2048.
  logic [11:0] lim_mult;  // Time limit step in base ticks.
  assign win_mult = dtwt_mult(odr, pmode, lowpass_filter_on, hybrid_mode);
  // Time limit steps are half the window steps; below 1.25 ms one base tick is used.
  assign lim_mult = (win_mult > 12'h001) ? (win_mult >> 1) : 12'h001;
  assign base_tick = (s_q.base_cnt == 24'(BASE_CYC - 1));

  // Divider and step counter update.
  always_comb begin
    s_d = s_q;
    if (base_tick) begin
      s_d.base_cnt = 24'h000000;
      s_d.step_cnt = (s_q.step_cnt == 11'(`DTWT_MAX_MULT * 2 - 1)) ? 11'h000
                                                                    : s_q.step_cnt + 11'h001;
    end else begin
      s_d.base_cnt = s_q.base_cnt + 24'h000001;
    end
  end

  // Registered state, synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Strobes fire when the step counter is a multiple of the step.
  // The step counter wraps at 2048, so even the longest hybrid step fires once per wrap.
  assign tk.win_tick = base_tick
                       && ((s_q.step_cnt & 11'(win_mult - 12'h001)) == 11'h000);
  assign tk.lat_tick = tk.win_tick;
  assign tk.lim_tick = base_tick
                       && ((s_q.step_cnt & 11'(lim_mult - 12'h001)) == 11'h000);
endmodule

// ===== rtl/dtwt_top.sv
// Double tap window timer: settings registers, latency and window sequencing.
//
// Function
// - Second pulse start must fall inside window.
// - Second pulse width below time limit.
// - Second pulse may end after window.
// - Window step by rate; max 255 steps.
// - Hybrid mode doubles every window step.
// - Filter-on step table per rate, mode.
// - Filter-off step table per rate, mode.
// - Ignore new starts during latency after first.
// - Valid pulse falls back within time limit.
`timescale 1ns/1ps
`include "dtwt_defines.svh"
module dtwt_top import dtwt_pkg::*; #(
  parameter int unsigned BASE_CYC = `DTWT_BASE_TICK_CYC
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Register interface write and read.
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Rate settings from the primary control register and mode logic.
  input  wire dtwt_odr_t  odr,
  input  wire dtwt_pm_t   pmode,
  input  wire logic       lowpass_filter_on,
  input  wire logic       hybrid_mode,
  // Detector configuration and threshold crossing level.
  input  wire logic       double_enable,
  input  wire logic       above_threshold,
  // Results.
  output logic            single_pulse,
  output logic            double_pulse,
  output logic            window_expired,
  output logic            latency_end,
  output logic            window_open
);
  // Step strobes from the generator.
  dtwt_tick_if tk ();

  // Step strobe generator.
  dtwt_step_gen #(
    .BASE_CYC (BASE_CYC)
  ) u_gen (
    .sys_clk           (sys_clk),
    .resetn            (resetn),
    .odr               (odr),
    .pmode             (pmode),
    .lowpass_filter_on (lowpass_filter_on),
    .hybrid_mode       (hybrid_mode),
    .tk                (tk)
  );

  // All state in one record.
  typedef struct packed {
    logic [7:0]  time_limit;  // Pulse time limit setting.
    logic [7:0]  latency;     // Latency setting.
    logic [7:0]  window;      // Second pulse window setting.
    dtwt_state_t st;          // Detector phase.
    logic [7:0]  cnt;         // Shared phase counter.
    logic        above_q;     // Previous threshold level.
    logic        single_p;    // Single pulse result pulse.
    logic        double_p;    // Double pulse result pulse.
    logic        expired_p;   // Window expired pulse.
    logic        lat_end_p;   // Latency end pulse.
    logic [7:0]  rdata;       // Read data.
  } dtwt_top_t;
  dtwt_top_t s_q, s_d;
  logic rise;  // Acceleration crosses above the threshold.
  logic fall;  // Acceleration drops back below it.

  // Edges of the threshold level against the previous cycle.
  assign rise = above_threshold && !s_q.above_q;
  assign fall = !above_threshold && s_q.above_q;

  // Next state: register access and the pulse sequence.
  always_comb begin
    s_d = s_q;
    s_d.above_q   = above_threshold;
    s_d.single_p  = 1'b0;
    s_d.double_p  = 1'b0;
    s_d.expired_p = 1'b0;
    s_d.lat_end_p = 1'b0;
    // Writes store the settings.
    if (reg_wr) begin
      case (reg_addr)
        `DTWT_OFS_TIME_LIMIT: begin
          s_d.time_limit = reg_wdata;
        end
        `DTWT_OFS_LATENCY: begin
          s_d.latency = reg_wdata;
        end
        `DTWT_OFS_WINDOW: begin
          s_d.window = reg_wdata;
        end
        default: begin
          // Writes to unmapped offsets are ignored.
        end
      endcase
    end
    // Reads return the setting or, at unmapped offsets, zero.
    // The read data then holds until the next read.
    if (reg_rd) begin
      case (reg_addr)
        `DTWT_OFS_TIME_LIMIT: s_d.rdata = s_q.time_limit;
        `DTWT_OFS_LATENCY:    s_d.rdata = s_q.latency;
        `DTWT_OFS_WINDOW:     s_d.rdata = s_q.window;
        default:              s_d.rdata = 8'h00;
      endcase
    end
    // Pulse sequence.
    case (s_q.st)
      DTWT_ST_IDLE: begin
        // Waiting for a first crossing.
        if (rise) begin
          // A crossing starts the first pulse and its width count.
          s_d.st  = DTWT_ST_FIRST;
          s_d.cnt = 8'h00;
        end
      end
      DTWT_ST_FIRST: begin
        // First pulse must fall back before the limit elapses.
        if (fall) begin
          // Fell back in time: a valid first pulse.
          s_d.single_p = 1'b1;
          s_d.cnt      = 8'h00;
          s_d.st       = double_enable ? DTWT_ST_LATENCY : DTWT_ST_IDLE;
        end else if (tk.lim_tick) begin
          if (s_q.cnt >= s_q.time_limit) begin
            // Too wide: the sequence is dropped without a result.
            s_d.st = DTWT_ST_IDLE;
          end else begin
            // One more limit step spent above the threshold.
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      end
      DTWT_ST_LATENCY: begin
        // New starts are ignored here.
        if (tk.lat_tick) begin
          if (s_q.cnt >= s_q.latency) begin
            // Latency over: the window opens with a cleared count.
            s_d.st        = DTWT_ST_WINDOW;
            s_d.cnt       = 8'h00;
            s_d.lat_end_p = 1'b1;
          end else begin
            // Still inside the latency interval.
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      end
      DTWT_ST_WINDOW: begin
        // Second start must come before the window count is reached.
        if (rise) begin
          // Start seen in time; from here only its width counts.
          s_d.st  = DTWT_ST_SECOND;
          s_d.cnt = 8'h00;
        end else if (tk.win_tick) begin
          if (s_q.cnt >= s_q.window) begin
            // Window used up with no second start.
            s_d.st        = DTWT_ST_IDLE;
            s_d.expired_p = 1'b1;
          end else begin
            // One more window step without a start.
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      end
      DTWT_ST_SECOND: begin
        // Window no longer matters; only the width limit does.
        if (fall) begin
          // A double result needs double detection still configured.
          s_d.double_p = double_enable;
          s_d.st       = DTWT_ST_IDLE;
        end else if (tk.lim_tick) begin
          if (s_q.cnt >= s_q.time_limit) begin
            // Second pulse too wide: no double result.
            s_d.st = DTWT_ST_IDLE;
          end else begin
            // One more limit step of the second pulse.
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      end
      default: begin
        // Unused phase codes fall back to idle.
        s_d.st = DTWT_ST_IDLE;
      end
    endcase
    // Without double detection nothing goes past the first pulse.
    if (!double_enable && s_q.st != DTWT_ST_FIRST) begin
      s_d.st = (s_d.st == DTWT_ST_FIRST) ? DTWT_ST_FIRST : DTWT_ST_IDLE;
    end
  end

  // Registered state, synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      // Settings, phase and result pulses restart from their reset values.
      s_q            <= '0;
      s_q.time_limit <= `DTWT_RST_SETTING;
      s_q.latency    <= `DTWT_RST_SETTING;
      s_q.window     <= `DTWT_RST_SETTING;
      s_q.st         <= DTWT_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come from flip-flops.
  assign reg_rdata      = s_q.rdata;
  assign single_pulse   = s_q.single_p;
  assign double_pulse   = s_q.double_p;
  assign window_expired = s_q.expired_p;
  assign latency_end    = s_q.lat_end_p;
  // The window level is decoded from the phase register.
  assign window_open    = (s_q.st == DTWT_ST_WINDOW);
endmodule

// ===== verification/dtwt_top_props.sv
// Port checks of the double tap window timer.
`timescale 1ns/1ps
module dtwt_top_props (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       resetn,
  // Register reads.
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // Detector inputs and results.
  input wire logic       double_enable,
  input wire logic       above_threshold,
  input wire logic       single_pulse,
  input wire logic       double_pulse,
  input wire logic       window_expired,
  input wire logic       latency_end,
  input wire logic       window_open
);
  // All checks share the one clock and reset.
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  single_fall_a:
    assert property (single_pulse |-> $past(above_threshold, 2) && !$past(above_threshold))
    else $error("single pulse not after a fall");
  double_fall_a:
    assert property (double_pulse |-> $past(above_threshold, 2) && !$past(above_threshold))
    else $error("double pulse not after a fall");
  single_one_cycle_a:
    assert property (single_pulse |=> !single_pulse)
    else $error("single pulse too long");
  double_needs_enable_a:
    assert property (double_pulse |-> $past(double_enable))
    else $error("double pulse while disabled");
  window_after_latency_a:
    assert property (latency_end |-> ##[0:1] window_open)
    else $error("window not opened");
  expiry_closes_a:
    assert property (window_expired |-> ##[0:1] !window_open)
    else $error("window open after expiry");
  double_or_expiry_a:
    assert property (double_pulse |-> !window_expired)
    else $error("double pulse with expiry");
  unmapped_zero_a:
    assert property (reg_rd && !(reg_addr inside {8'h26, 8'h27, 8'h28}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Main scenarios seen.
  cover property (double_pulse);
  cover property (window_expired);
  cover property (latency_end ##1 window_open);
endmodule
bind dtwt_top dtwt_top_props u_props (.sys_clk(sys_clk), .resetn(resetn), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .double_enable(double_enable),
  .above_threshold(above_threshold), .single_pulse(single_pulse), .double_pulse(double_pulse),
  .window_expired(window_expired), .latency_end(latency_end), .window_open(window_open));

// ===== verification/dtwt_host.sv
// Host model that reaches the settings registers.
`timescale 1ns/1ps
module dtwt_host (
  // Clock.
  input wire logic  sys_clk,
  // Register strobes, address and data.
  output logic      reg_wr,
  output logic      reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // Strobes idle low from time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'h00;
  end
  // One access: a single-cycle strobe, then address and data are inverted.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench of the double tap window timer.
`timescale 1ns/1ps
module tb_top import dtwt_pkg::*; ();
  logic       sys_clk, resetn, reg_wr, reg_rd, lpf, hyb, den, above, rd_pend;
  logic       sp, dp, wx, le, wo;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  dtwt_odr_t  odr;
  dtwt_pm_t   pm;
  logic [9:0] q[$];
  int         fails, n_checks, cyc, n;
  int         ot[5] = '{0, 0, 0, 1, 7};
  int         pc[5] = '{0, 0, 0, 0, 3};
  int         lf[5] = '{0, 0, 1, 1, 0};
  int         hb[5] = '{0, 1, 0, 0, 0};
  int         st[5] = '{10, 20, 20, 40, 5120};
  dtwt_host u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  dtwt_top #(.BASE_CYC(10)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .odr(odr), .pmode(pm), .lowpass_filter_on(lpf), .hybrid_mode(hyb), .double_enable(den),
    .above_threshold(above), .single_pulse(sp), .double_pulse(dp), .window_expired(wx),
    .latency_end(le), .window_open(wo));
  // Clock of 8 ns.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Closing report.
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input logic [9:0] s, input logic [9:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // An output event is matched against the oldest note.
  task automatic take(input logic [9:0] s);
    if (q.size() == 0) chk(s, 10'h3FF, "event");
    else chk(s, q.pop_front(), "event");
  endtask
  always @(negedge sys_clk) begin
    if (rd_pend) take({2'h0, reg_rdata});
    rd_pend = reg_rd;
    if (sp) take(10'h100);
    if (dp) take(10'h200);
    if (wx) take(10'h300);
  end
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(input int k);
    step(1);
    above = 1'b1;
    step(k);
    above = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({2'h0, e});
    u_host.acc(1'b0, a, 8'h00);
  endtask
  // Waits for latency end (0) or expiry (1), counting cycles in n.
  task automatic wt(input bit x);
    n = 0;
    while ((x ? wx : le) !== 1'b1 && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic ev(input logic [9:0] a, input logic [9:0] b);
    q.push_back(a);
    q.push_back(b);
  endtask
  initial begin
    {resetn, above, lpf, hyb, rd_pend, fails, n_checks, cyc} = '0;
    den = 1'b1;
    odr = DTWT_ODR_800;
    pm = DTWT_PM_NORMAL;
    rv = 8'($urandom(79906));
    rv = 8'($urandom);
    step(16);
    resetn = 1'b1;
    for (int a = 38; a <= 40; a++) rd(8'(a), 8'h00);
    u_host.acc(1'b1, 8'h28, rv);
    u_host.acc(1'b1, 8'h2F, 8'h5A);
    rd(8'h28, rv);
    rd(8'h2F, 8'h00);
    $display("test regs done");
    u_host.acc(1'b1, 8'h26, 8'h04);
    u_host.acc(1'b1, 8'h27, 8'h03);
    u_host.acc(1'b1, 8'h28, 8'h03);
    ev(10'h100, 10'h200);
    pulse(2);
    wt(0);
    pulse(2);
    step(20);
    // Second start inside a short window, end well after it.
    u_host.acc(1'b1, 8'h28, 8'h01);
    ev(10'h100, 10'h200);
    pulse(2);
    wt(0);
    pulse(35);
    step(20);
    // A start during latency is ignored, so the window runs out.
    ev(10'h100, 10'h300);
    pulse(2);
    step(3);
    pulse(2);
    wt(0);
    wt(1);
    step(5);
    // Over the time limit: no event at all.
    pulse(100);
    step(20);
    // Double detection off: first pulse only.
    den = 1'b0;
    q.push_back(10'h100);
    pulse(2);
    step(200);
    den = 1'b1;
    $display("test pulses done");
    u_host.acc(1'b1, 8'h27, 8'h01);
    u_host.acc(1'b1, 8'h28, 8'h03);
    for (int i = 0; i < 5; i++) begin
      odr = dtwt_odr_t'(ot[i]);
      pm = dtwt_pm_t'(pc[i]);
      lpf = lf[i][0];
      hyb = hb[i][0];
      ev(10'h100, 10'h300);
      pulse(2);
      wt(0);
      wt(1);
      chk({9'h000, n >= 3 * st[i] && n <= 5 * st[i]}, 10'h001, "window");
      step(5);
    end
    chk(10'(q.size()), 10'h000, "queue");
    $display("test rates done");
    end_sim();
  end
endmodule
